// ===== src/biss_pkg.sv
// Shared constants and state codes for the frame capture block
// How it works
// - After delay, wait clock, sample at compensated point
// - Start state times processing until start bit
// - Processing timer saturates; last value readable
// - Control bit sampled cycle after start bit
// - Inverted control bit captured at timeout
// - Keep only latest frame's two control bits
// - Accept zero to 250 data bits silently
// - Sample every cycle until timeout; count bits
// - Bits packed MSB first into byte cells
// - Last byte may be partial; host masks
// - Timeout in delay/ready ends frame cleanly
// - Timeout in measure/start/control flags error
// - Interrupt pulse on switch; ends early on transfer
// - Every timeout sets seen flag, bumps tally
// - Data ready only when bank readable
// - Frame read clears tally, ready, seen
// - Frozen tally saturates at 0x3fff
// - Two banks, 250 bits each
// - Idle host: alternate banks, read newest
// - Busy read: seen/tally now, ready/irq later
// - Busy read: no switch, overwrite write bank
// - Overlap gives no interrupt, flags collision
// - Eight states, three-bit codes
// - Timeout period from first 1.5 clock periods
package biss_pkg;
  localparam int TO_W = 16;
  localparam logic [TO_W-1:0] TO_MAX = 16'hffff;
  localparam int PT_W = 12;
  localparam logic [PT_W-1:0] PT_MAX = 12'hfff;
  localparam int TALLY_W = 14;
  localparam logic [TALLY_W-1:0] TALLY_MAX = 14'h3fff;
  localparam int MAX_BITS = 250;
  localparam int BCNT_W = 8;
  localparam int BANK_BYTES = 32;
  localparam int ADDR_W = 5;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_MHZ = 250;
  localparam int IRQ_PULSE_NS = 2000;
  localparam int IRQ_CYC = IRQ_PULSE_NS * CLK_MHZ / 1000;
  localparam int IRQ_W = 10;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_MEAS  = 3'b001,
    ST_DELAY = 3'b010,
    ST_READY = 3'b011,
    ST_START = 3'b100,
    ST_CTRL  = 3'b101,
    ST_DATA  = 3'b110,
    ST_ERROR = 3'b111
  } state_t;
endpackage

// ===== src/byte_stream_if.sv
// Byte stream with valid and ready between internal modules
`timescale 1ns/1ps
interface byte_stream_if;
  logic [7:0] data;
  logic       valid;
  logic       ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ===== src/sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic d,
  output logic      q
);
  logic meta_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= 1'b1;
      q      <= 1'b1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // sync2

// ===== src/byte_fifo.sv
// Flop-based FIFO, width and depth as parameters
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic    clk,
  input  wire logic    reset,
  byte_stream_if.snk   in_s,
  byte_stream_if.src   out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;
  assign in_s.ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data  = mem_q[rp_q];
  assign push = in_s.valid & in_s.ready;
  assign pop  = out_s.valid & out_s.ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_s.data;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // byte_fifo

// ===== src/biss_frame_capture_banks.sv
// Passive frame listener with two alternating frame banks
`timescale 1ns/1ps
module biss_frame_capture_banks (
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire logic                         master_clock_line,
  input  wire logic                         slave_data_line,
  input  wire logic                         spi_active,
  input  wire logic                         spi_frame_read,
  input  wire logic                         err_clear,
  input  wire logic [biss_pkg::ADDR_W-1:0]  rd_addr,
  output logic      [7:0]                   rd_data,
  output logic      [2:0]                   device_state_reg,
  output logic                              device_fault_reg,
  output logic                              irq,
  output logic                              data_ready_flag,
  output logic                              frame_seen,
  output logic      [biss_pkg::TALLY_W-1:0] frozen_frame_tally,
  output logic      [biss_pkg::BCNT_W-1:0]  bit_count,
  output logic      [biss_pkg::PT_W-1:0]    proc_time,
  output logic      [biss_pkg::TO_W-1:0]    line_delay,
  output logic                              ctrl_bit,
  output logic                              ctrl_bit_inv,
  output logic                              bank_collision,
  output logic                              read_bank
);
  biss_pkg::state_t state_q;
  logic lc_s;
  logic sl_s;
  logic lc_q;
  logic lc_rise;
  logic lc_chg;
  logic [1:0] rise_cnt_q;
  logic [biss_pkg::TO_W-1:0] to_cnt_q;
  logic [biss_pkg::TO_W-1:0] to_len_q;
  logic [biss_pkg::TO_W-1:0] per_cnt_q;
  logic [biss_pkg::TO_W-1:0] smp_cnt_q;
  logic smp_arm_q;
  logic smp;
  logic timeout;
  logic [7:0] acc_q;
  logic [2:0] nb_q;
  logic push_vld_q;
  logic [7:0] push_dat_q;
  logic stall;
  logic end_pend_q;
  logic commit;
  logic [biss_pkg::ADDR_W-1:0] wptr_q;
  logic wr_bank_q;
  logic [7:0] bank_q [2][biss_pkg::BANK_BYTES];
  logic [biss_pkg::TALLY_W-1:0] tally_q;
  logic defer_q;
  logic rd_q;
  logic act_q;
  logic rd_rise;
  logic rd_fall;
  logic act_rise;
  logic switch_go;
  logic collide;
  logic [biss_pkg::IRQ_W-1:0] irq_cnt_q;

  byte_stream_if fill_s ();
  byte_stream_if drain_s ();

  sync2 u_sync_lc (
    .clk   (clk),
    .reset (reset),
    .d     (master_clock_line),
    .q     (lc_s)
  );

  sync2 u_sync_sl (
    .clk   (clk),
    .reset (reset),
    .d     (slave_data_line),
    .q     (sl_s)
  );

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (biss_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk   (clk),
    .reset (reset),
    .in_s  (fill_s),
    .out_s (drain_s)
  );

  assign lc_rise = lc_s & ~lc_q;
  assign lc_chg  = lc_s ^ lc_q;
  assign smp     = smp_arm_q && (smp_cnt_q == '0);
  // Frame end: no clock change within the measured period, or for TO_MAX cycles while measuring
  assign timeout = (state_q != biss_pkg::ST_IDLE) && !lc_chg &&
                   (state_q == biss_pkg::ST_MEAS ? to_cnt_q == biss_pkg::TO_MAX
                                                : to_cnt_q >= to_len_q);
  assign stall   = push_vld_q && !fill_s.ready;
  assign fill_s.valid = push_vld_q;
  assign fill_s.data  = push_dat_q;
  assign commit  = end_pend_q && !drain_s.valid && !push_vld_q;
  assign drain_s.ready = !commit;
  assign rd_rise  = spi_frame_read & ~rd_q;
  assign rd_fall  = rd_q & ~spi_frame_read;
  assign act_rise = spi_active & ~act_q;
  // Newest frame made readable now, or after the read ends
  assign switch_go = (commit && !spi_frame_read) ||
                     (rd_fall && defer_q && state_q == biss_pkg::ST_IDLE);
  assign collide   = rd_fall && defer_q && state_q != biss_pkg::ST_IDLE;

  always_ff @(posedge clk) begin
    if (reset) begin
      lc_q  <= 1'b1;
      rd_q  <= 1'b0;
      act_q <= 1'b0;
    end else begin
      lc_q  <= lc_s;
      rd_q  <= spi_frame_read;
      act_q <= spi_active;
    end
  end

  // Frame controller
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= biss_pkg::ST_IDLE;
    end else if (timeout) begin
      state_q <= biss_pkg::ST_IDLE;
    end else begin
      case (state_q)
        biss_pkg::ST_IDLE:
          if (lc_chg && !lc_s) state_q <= biss_pkg::ST_MEAS;
        biss_pkg::ST_MEAS:
          if (lc_rise && rise_cnt_q == 2'h1) begin
            state_q <= sl_s ? biss_pkg::ST_DELAY : biss_pkg::ST_ERROR;
          end
        biss_pkg::ST_DELAY:
          if (!sl_s) state_q <= biss_pkg::ST_READY;
        biss_pkg::ST_READY:
          if (lc_rise) state_q <= biss_pkg::ST_START;
        biss_pkg::ST_START:
          if (smp && sl_s) state_q <= biss_pkg::ST_CTRL;
        biss_pkg::ST_CTRL:
          if (smp) state_q <= biss_pkg::ST_DATA;
        biss_pkg::ST_DATA:
          state_q <= biss_pkg::ST_DATA;
        biss_pkg::ST_ERROR:
          state_q <= biss_pkg::ST_ERROR;
        default:
          state_q <= biss_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      device_state_reg <= 3'h0;
    end else begin
      device_state_reg <= state_q;
    end
  end

  // Timeout measurement
  always_ff @(posedge clk) begin
    if (reset) begin
      to_cnt_q   <= '0;
      per_cnt_q  <= '0;
      to_len_q   <= biss_pkg::TO_MAX;
      rise_cnt_q <= 2'h0;
    end else if (state_q == biss_pkg::ST_IDLE) begin
      to_cnt_q   <= '0;
      per_cnt_q  <= '0;
      rise_cnt_q <= 2'h0;
    end else begin
      to_cnt_q <= lc_chg ? '0 : to_cnt_q + (to_cnt_q != biss_pkg::TO_MAX);
      if (state_q == biss_pkg::ST_MEAS) begin
        per_cnt_q <= per_cnt_q + (per_cnt_q != biss_pkg::TO_MAX);
        if (lc_rise) rise_cnt_q <= rise_cnt_q + 2'h1;
        if (lc_rise && rise_cnt_q == 2'h1) to_len_q <= per_cnt_q;
      end
    end
  end

  // Line delay and compensated sample point
  always_ff @(posedge clk) begin
    if (reset) begin
      line_delay <= '0;
      smp_cnt_q  <= '0;
      smp_arm_q  <= 1'b0;
    end else begin
      if (state_q == biss_pkg::ST_MEAS && lc_rise) line_delay <= '0;
      else if (state_q == biss_pkg::ST_DELAY && sl_s)
        line_delay <= line_delay + (line_delay != biss_pkg::TO_MAX);
      if (state_q == biss_pkg::ST_IDLE) begin
        smp_arm_q <= 1'b0;
      end else if (lc_rise && state_q >= biss_pkg::ST_READY) begin
        smp_cnt_q <= line_delay;
        smp_arm_q <= 1'b1;
      end else if (smp) begin
        smp_arm_q <= 1'b0;
      end else if (smp_arm_q) begin
        smp_cnt_q <= smp_cnt_q - 1'b1;
      end
    end
  end

  // Processing time and control bits
  always_ff @(posedge clk) begin
    if (reset) begin
      proc_time    <= '0;
      ctrl_bit     <= 1'b0;
      ctrl_bit_inv <= 1'b0;
    end else begin
      if (state_q == biss_pkg::ST_READY) proc_time <= '0;
      else if (state_q == biss_pkg::ST_START)
        proc_time <= proc_time + (proc_time != biss_pkg::PT_MAX);
      if (state_q == biss_pkg::ST_CTRL && smp) ctrl_bit <= sl_s;
      if (timeout) ctrl_bit_inv <= sl_s;
    end
  end

  // Bit packing into bytes
  always_ff @(posedge clk) begin
    if (reset) begin
      acc_q      <= 8'h00;
      nb_q       <= 3'h0;
      bit_count  <= '0;
      push_vld_q <= 1'b0;
      push_dat_q <= 8'h00;
      end_pend_q <= 1'b0;
    end else begin
      if (fill_s.ready) push_vld_q <= 1'b0;
      if (commit) end_pend_q <= 1'b0;
      if (state_q == biss_pkg::ST_IDLE && lc_chg && !lc_s) begin
        acc_q     <= 8'h00;
        nb_q      <= 3'h0;
        bit_count <= '0;
      end else if (timeout) begin
        end_pend_q <= 1'b1;
        if (nb_q != 3'h0 && !stall) begin
          push_dat_q <= acc_q;
          push_vld_q <= 1'b1;
        end
      end else if (state_q == biss_pkg::ST_DATA && smp && !stall &&
                   bit_count != biss_pkg::BCNT_W'(biss_pkg::MAX_BITS)) begin
        acc_q     <= (nb_q == 3'h7) ? 8'h00 : {acc_q[6:0], sl_s};
        nb_q      <= nb_q + 3'h1;
        bit_count <= bit_count + 1'b1;
        if (nb_q == 3'h7) begin
          push_dat_q <= {acc_q[6:0], sl_s};
          push_vld_q <= 1'b1;
        end
      end
    end
  end

  // Bank storage
  always_ff @(posedge clk) begin
    if (drain_s.valid && drain_s.ready) bank_q[wr_bank_q][wptr_q] <= drain_s.data;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wptr_q    <= '0;
      wr_bank_q <= 1'b0;
      read_bank <= 1'b1;
      rd_data   <= 8'h00;
    end else begin
      rd_data <= bank_q[read_bank][rd_addr];
      if (state_q == biss_pkg::ST_IDLE && lc_chg && !lc_s) wptr_q <= '0;
      else if (drain_s.valid && drain_s.ready) wptr_q <= wptr_q + 1'b1;
      if (switch_go) begin
        read_bank <= wr_bank_q;
        wr_bank_q <= ~wr_bank_q;
      end
    end
  end

  // Tally, flags and deferred switch
  always_ff @(posedge clk) begin
    if (reset) begin
      tally_q            <= '0;
      frozen_frame_tally <= '0;
      frame_seen         <= 1'b0;
      data_ready_flag    <= 1'b0;
      defer_q            <= 1'b0;
      bank_collision     <= 1'b0;
    end else begin
      if (commit) begin
        tally_q <= rd_rise ? 14'h0001 : tally_q + (tally_q != biss_pkg::TALLY_MAX);
        frame_seen <= 1'b1;
      end else if (rd_rise) begin
        tally_q    <= '0;
        frame_seen <= 1'b0;
      end
      if (rd_rise) frozen_frame_tally <= tally_q;
      if (switch_go) data_ready_flag <= 1'b1;
      else if (rd_rise) data_ready_flag <= 1'b0;
      if (commit && spi_frame_read) defer_q <= 1'b1;
      else if (rd_fall) defer_q <= 1'b0;
      if (collide) bank_collision <= 1'b1;
      else if (rd_rise) bank_collision <= 1'b0;
    end
  end

  // Protocol fault and interrupt pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      device_fault_reg <= 1'b0;
    end else if (timeout && (state_q == biss_pkg::ST_MEAS ||
                 state_q == biss_pkg::ST_START || state_q == biss_pkg::ST_CTRL)) begin
      device_fault_reg <= 1'b1;
    end else if (state_q == biss_pkg::ST_MEAS && lc_rise && rise_cnt_q == 2'h1 && !sl_s) begin
      device_fault_reg <= 1'b1;
    end else if (err_clear) begin
      device_fault_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq       <= 1'b0;
      irq_cnt_q <= '0;
    end else if (switch_go) begin
      irq       <= 1'b1;
      irq_cnt_q <= biss_pkg::IRQ_W'(biss_pkg::IRQ_CYC - 1);
    end else if (act_rise || irq_cnt_q == '0) begin
      irq <= 1'b0;
    end else begin
      irq_cnt_q <= irq_cnt_q - 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_ctrl_sample;
    state_q == biss_pkg::ST_CTRL && smp;
  endsequence
  sequence s_in_data;
    state_q == biss_pkg::ST_DATA;
  endsequence

  AST_CTRL_SAMPLE: assert property (
    (s_ctrl_sample and !timeout) |=> s_in_data ##0 ctrl_bit == $past(sl_s))
    else $error("control bit not taken");
  AST_PROTO_ERR: assert property (
    timeout && state_q == biss_pkg::ST_START |=> device_fault_reg && state_q == biss_pkg::ST_IDLE)
    else $error("protocol error not flagged");
  AST_REDUCED_OK: assert property (
    timeout && state_q == biss_pkg::ST_READY && !err_clear |=> $stable(device_fault_reg))
    else $error("reduced frame raised error");
  AST_SEEN_TALLY: assert property (
    frame_seen == (tally_q != '0))
    else $error("seen flag and tally disagree");
  AST_TALLY_SAT: assert property (
    tally_q == biss_pkg::TALLY_MAX && commit && !rd_rise |=> tally_q == biss_pkg::TALLY_MAX)
    else $error("tally wrapped");
  AST_IRQ_PULSE: assert property (
    switch_go |=> irq && data_ready_flag ##1 (irq || act_q) [*3])
    else $error("interrupt pulse wrong");
  AST_DEFER: assert property (
    commit && spi_frame_read && !rd_rise |=> frame_seen && defer_q && !switch_go)
    else $error("busy read not deferred");
  AST_COLLIDE: assert property (
    collide |=> bank_collision && $stable(read_bank) && !$rose(irq))
    else $error("collision not flagged");
  AST_BIT_COUNT: assert property (
    s_in_data ##0 (smp && !stall && !timeout &&
                   bit_count < biss_pkg::BCNT_W'(biss_pkg::MAX_BITS))
    |=> bit_count == $past(bit_count) + 8'h01)
    else $error("bit not counted");
endmodule // biss_frame_capture_banks

// ===== verification/biss_link_model.sv
// Behavioural link master and slave driving the clock and data lines
`timescale 1ns/1ps
module biss_link_model (
  output logic master_clock_line,
  output logic slave_data_line
);
  localparam int PROC = 2;

  initial begin
    master_clock_line = 1'b1;
    slave_data_line   = 1'b1;
  end

  // Modes: 0 normal, 1 reduced, 2 data low at second rise, 3 stop before start bit
  task automatic send(input logic [1:0] mode, input int n, input logic [249:0] v,
                      input logic cds, input logic endl);
    int rises;
    rises = (mode == 2'd1) ? 2 : (mode == 2'd3) ? 2 + PROC : n + PROC + 4;
    #1.3;
    master_clock_line = 1'b0;
    for (int k = 1; k <= rises; k++) begin
      #40;
      if (mode == 2'd2 && k == 2) begin
        slave_data_line = 1'b0;
      end
      // Second rise 1.5 periods after the opening fall
      master_clock_line = 1'b1;
      #20;
      // Ack, processing, start bit, control bit, data MSB first
      if (k >= 2) begin
        slave_data_line = (k <= 2 + PROC) ? 1'b0 : (k == 3 + PROC) ? 1'b1 :
                          (k == 4 + PROC) ? cds : v[n + PROC + 4 - k];
      end
      if (k < rises) begin
        #20;
        master_clock_line = 1'b0;
      end
    end
    // Clock stays high so the frame times out; data shows end level
    #40;
    slave_data_line = endl;
    #400;
    slave_data_line = 1'b1;
  endtask
endmodule // biss_link_model

// ===== verification/testbench.sv
// Self-checking bench for the frame capture block
`timescale 1ns/1ps
module testbench;
  logic                           clk, reset, spi_active, spi_frame_read, err_clear;
  logic [biss_pkg::ADDR_W-1:0]    rd_addr;
  logic [7:0]                     rd_data;
  logic [2:0]                     device_state_reg;
  logic                           device_fault_reg, irq, data_ready_flag, frame_seen;
  logic [biss_pkg::TALLY_W-1:0]   frozen_frame_tally;
  logic [biss_pkg::BCNT_W-1:0]    bit_count;
  logic [biss_pkg::PT_W-1:0]      proc_time;
  logic [biss_pkg::TO_W-1:0]      line_delay;
  logic                           ctrl_bit, ctrl_bit_inv, bank_collision, read_bank;
  logic                           master_clock_line, slave_data_line;
  int                             n_errors = 0;
  int                             compares = 0;
  int                             irq_cnt  = 0;

  biss_frame_capture_banks dut (.clk, .reset, .master_clock_line, .slave_data_line,
    .spi_active, .spi_frame_read, .err_clear, .rd_addr, .rd_data, .device_state_reg,
    .device_fault_reg, .irq, .data_ready_flag, .frame_seen, .frozen_frame_tally,
    .bit_count, .proc_time, .line_delay, .ctrl_bit, .ctrl_bit_inv, .bank_collision,
    .read_bank);
  biss_link_model link (.master_clock_line, .slave_data_line);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic irq_low;
    int i;
    i = 0;
    @(negedge clk);
    while (irq !== 1'b0 && i < 1000) begin
      @(negedge clk);
      i++;
    end
    chk(irq, 0);
  endtask

  // Expected byte j: frame bits 8j.. shifted in at the low end
  function automatic logic [7:0] expb(input logic [249:0] v, input int n, input int j);
    logic [7:0] b;
    b = 8'h00;
    for (int p = 8 * j; p < 8 * j + 8 && p < n; p++) b = {b[6:0], v[n - 1 - p]};
    return b;
  endfunction

  task automatic t_frame(input int n, input logic [249:0] v, input logic c, input logic e);
    logic rb;
    @(posedge clk);
    rb = read_bank;
    irq_cnt = 0;
    link.send(2'd0, n, v, c, e);
    cyc(10);
    @(negedge clk);
    chk(frame_seen, 1);
    chk(read_bank, !rb);
    chk(data_ready_flag, 1);
    chk(irq, 1);
    chk(bit_count, n);
    chk(ctrl_bit, c);
    chk(ctrl_bit_inv, e);
    chk(device_fault_reg, 0);
    chk(device_state_reg, 0);
    chk(proc_time != 0, 1);
    // Slave answers 5 cycles after a rise; count starts one cycle after the edge
    chk(line_delay, 16'h0004);
    for (int j = 0; j < (n + 7) / 8; j++) begin
      @(posedge clk);
      rd_addr <= 5'(j);
      cyc(2);
      @(negedge clk);
      chk(rd_data, expb(v, n, j));
    end
    irq_low;
    chk(irq_cnt, biss_pkg::IRQ_CYC);
    $display("frame test done, %0d bits", n);
  endtask

  task automatic t_read(input logic [13:0] ft);
    @(posedge clk);
    spi_active <= 1'b1;
    spi_frame_read <= 1'b1;
    cyc(2);
    @(negedge clk);
    chk(frozen_frame_tally, ft);
    chk(frame_seen, 0);
    chk(data_ready_flag, 0);
    chk(irq, 0);
    chk(bank_collision, 0);
    @(posedge clk);
    spi_active <= 1'b0;
    spi_frame_read <= 1'b0;
    cyc(2);
    $display("read test done");
  endtask

  task automatic t_busy;
    logic rb;
    @(posedge clk);
    spi_frame_read <= 1'b1;
    cyc(2);
    rb = read_bank;
    link.send(2'd0, 16, {234'h0, 16'h0f0f}, 1'b0, 1'b1);
    link.send(2'd0, 8, {242'h0, 8'h3c}, 1'b1, 1'b0);
    cyc(10);
    @(negedge clk);
    chk(frame_seen, 1);
    chk(data_ready_flag, 0);
    chk(irq, 0);
    chk(read_bank, rb);
    @(posedge clk);
    spi_frame_read <= 1'b0;
    rd_addr <= 5'h00;
    cyc(3);
    @(negedge clk);
    chk(data_ready_flag, 1);
    chk(irq, 1);
    chk(read_bank, !rb);
    chk(rd_data, 8'h3c);
    t_read(14'h0002);
    irq_low;
    $display("busy read test done");
  endtask

  task automatic t_collide;
    logic rb;
    @(posedge clk);
    spi_frame_read <= 1'b1;
    link.send(2'd0, 8, {242'h0, 8'h81}, 1'b0, 1'b0);
    cyc(10);
    rb = read_bank;
    fork
      link.send(2'd0, 40, {210'h0, 40'h123456789a}, 1'b1, 1'b0);
      begin
        // Read ends while the next frame is still arriving
        cyc(250);
        spi_frame_read <= 1'b0;
        cyc(3);
        @(negedge clk);
        chk(bank_collision, 1);
        chk(irq, 0);
        chk(read_bank, rb);
      end
    join
    cyc(10);
    irq_low;
    t_read(14'h0002);
    $display("collision test done");
  endtask

  task automatic t_faults;
    for (int m = 1; m < 4; m++) begin
      link.send(2'(m), 4, {246'h0, 4'h5}, 1'b0, 1'b0);
      cyc(10);
      @(negedge clk);
      chk(frame_seen, 1);
      chk(device_fault_reg, m > 1);
      chk(device_state_reg, 0);
      @(posedge clk);
      err_clear <= 1'b1;
      @(posedge clk);
      err_clear <= 1'b0;
      cyc(2);
      @(negedge clk);
      chk(device_fault_reg, 0);
    end
    $display("fault test done");
  endtask

  task automatic finish_test;
    $display("compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #300000;
    n_errors++;
    finish_test;
  end

  initial begin
    reset = 1'b1;
    spi_active = 1'b0;
    spi_frame_read = 1'b0;
    err_clear = 1'b0;
    rd_addr = 5'h00;
    cyc(10);
    reset <= 1'b0;
    cyc(2);
    @(negedge clk);
    chk(read_bank, 1);
    chk(device_state_reg, 0);
    chk({frame_seen, data_ready_flag, irq, device_fault_reg}, 0);
    chk(frozen_frame_tally, 0);
    $display("reset test done");
    t_frame(29, {221'h0, 29'h1a2b3c4d}, 1'b1, 1'b0);
    t_frame(0, 250'h0, 1'b0, 1'b1);
    t_read(14'h0002);
    t_frame(250, {{31{8'h96}}, 2'b10}, 1'b1, 1'b1);
    t_read(14'h0001);
    t_busy;
    t_collide;
    t_faults;
    finish_test;
  end
endmodule // testbench
